/* src/lfc_pkg.sv */
// constants, types and state layout of the limiter and fault control block
package lfc_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_LIM_CTRL = 8'h08;
	localparam logic [7:0] ADDR_THR_SLOPE = 8'h09;
	localparam logic [7:0] ADDR_BAT_INFL = 8'h0a;
	localparam logic [7:0] ADDR_REC_CTRL = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h11;
	localparam logic [7:0] ADDR_BAT_VOLT = 8'h13;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int LC_RRT_LSB = 6;
	localparam int LC_ATR_LSB = 4;
	localparam int LC_TRACK_BIT = 2;
	localparam int LC_MODE_LSB = 0;
	localparam int TS_THR_LSB = 3;
	localparam int TS_SLOPE_LSB = 0;
	localparam int RC_GAIN_LSB = 6;
	localparam int RC_MANUAL_RECOVERY_TRIGGER_BIT = 5;
	localparam int RC_AR_LSB = 3;
	localparam int RC_UV_BIT = 2;
	localparam int RC_OT_BIT = 1;
	localparam int RC_OC_BIT = 0;
	localparam int ST_VREG_BIT = 7;
	localparam int ST_SUPPLY_BIT = 6;
	localparam int ST_LIM_BIT = 5;
	localparam int ST_CLIP_BIT = 4;
	localparam int ST_OC_BIT = 3;
	localparam int ST_OT_BIT = 2;
	localparam int ST_WARN_BIT = 1;
	localparam int ST_BAT_BIT = 0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] LIM_CTRL_RST = 8'h00;
	localparam logic [7:0] THR_SLOPE_RST = 8'hf8;
	localparam logic [7:0] BAT_INFL_RST = 8'h00;
	localparam logic [7:0] REC_CTRL_RST = 8'h07;
	localparam logic [7:0] UNITY_GAIN = 8'hff;

	// ----------------------------------------------------------------
	// limiter scaling (levels in eighths of a volt peak)
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_ON = 2'h1;
	localparam logic [1:0] MODE_MUTE = 2'h2;
	localparam logic [1:0] MODE_LOW = 2'h3;
	localparam logic [8:0] THR_BASE = 9'h010;
	localparam logic [8:0] THR_STEP = 9'h004;
	localparam logic [8:0] THR_MAX = 9'h080;
	localparam logic [17:0] BAT_SCALE = 18'h00070;
	localparam logic [8:0] HYST_CODES = 9'h004;
	localparam logic [7:0] WARN_CAP0 = 8'hff;
	localparam logic [7:0] WARN_CAP1 = 8'hb4;
	localparam logic [7:0] WARN_CAP2 = 8'h80;
	localparam logic [7:0] WARN_CAP3 = 8'h5a;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int RATE_BASE_NS = 320;
	localparam int RATE_BASE_CYC = (RATE_BASE_NS * CLK_MHZ + 999) / 1000;
	localparam int RETRY_TIME_US = 100;
	localparam int RETRY_CYC = RETRY_TIME_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_WAIT = 3'b010,
		ST_HALT = 3'b100
	} lfc_fsm_e;

	typedef struct packed {
		logic vreg_low;
		logic supply_low;
		logic overcurrent;
		logic over_temp;
		logic temp_warn;
		logic clip;
	} lfc_sense_s;

	typedef struct packed {
		lfc_fsm_e st;
		logic [7:0] lim_ctrl;
		logic [7:0] thr;
		logic [7:0] infl;
		logic [7:0] rec;
		logic [7:0] vbat;
		logic [7:0] status;
		logic [7:0] rdata;
		logic [7:0] gain;
		logic [7:0] out_gain;
		logic [3:0] flt;
		logic below;
		logic amp_en;
		logic mute;
		logic [1:0] tries;
		logic [12:0] rate_cnt;
		logic [23:0] wait_cnt;
	} lfc_state_s;

endpackage

/* src/lfc_core.sv */
// limiter, battery tracking, fault flags and fault recovery control
`timescale 1ns/1ps

// Summary of operation
// - battery converter byte is held in the read-only battery register
// - battery code N means 4 V plus 14 V times N over 255
// - status bit 7 set while regulator supply is under 3.6 V
// - status bit 6 set while main supply is under 3.6 V
// - overcurrent flag set when output current exceeds 6 A peak
// - overtemperature flag above 145 C, separate warning flag above 117 C
// - all fault flags readable in status register at 0x11
// - recovery bits 7:6 pick gain cut during thermal warning
// - writing recovery bit 5 starts a recovery attempt
// - recovery bits 4:3 set number of automatic attempts
// - bits 2,1,0 pick auto or manual for uv, ot, oc
// - automatic mode retries, refaults if condition persists, repeats
// - manual mode stays shut down until software asks for recovery
// - threshold bits 7:3 set limit level from 2 to 16 V peak
// - above threshold output is held to limit, below passes unchanged
// - limiter control bit 2 picks fixed or battery-tracking threshold
// - inflection point is 8-bit battery_inflection_level, battery code scale
// - slope bits 1:0 set threshold drop per battery drop, 1:1..4:1
// - mode 00 off, 01 limit, 10 mute below point, 11 limit below
// - tracking lowers threshold only while battery is below the point
// - hysteresis above the inflection point before disengaging
// - gain falls at attack rate, recovers at release rate
module lfc_core
	import lfc_pkg::*;
#(
	parameter int RETRY_CYCLES = RETRY_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	input wire logic i_adc_valid,
	input wire logic [7:0] i_adc_code,
	input wire lfc_sense_s i_sense,
	input wire logic [7:0] i_out_level,
	output logic [7:0] o_reg_rdata,
	output logic o_amp_enable,
	output logic [7:0] o_gain,
	output logic o_mute
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] lfc_scale(input logic [7:0] lvl,
			input logic [7:0] g);
		logic [15:0] p;
		p = 16'(lvl) * 16'(g);
		return p[15:8];
	endfunction

	function automatic logic [12:0] lfc_period(input logic [1:0] rate);
		logic [12:0] base;
		base = 13'(RATE_BASE_CYC);
		return base << {rate, 1'b0};
	endfunction

	// code N of the battery scale is 14/255 V, i.e. 112/255 eighths of a
	// volt; a shift by 8 stands in for the 255 divide, under 0.4 % low
	function automatic logic [7:0] lfc_threshold(input logic [7:0] thr,
			input logic [7:0] infl, input logic [7:0] vbat,
			input logic track, input logic below);
		logic [8:0] base;
		logic [7:0] drop;
		logic [17:0] red;
		base = THR_BASE + 9'(thr[7:TS_THR_LSB]) * THR_STEP;
		if (base > THR_MAX) begin
			base = THR_MAX;
		end
		drop = (below && vbat < infl) ? infl - vbat : 8'h00;
		red = (18'(drop) * 18'({1'b0, thr[1:TS_SLOPE_LSB]} + 3'h1)
			* BAT_SCALE) >> 8;
		if (track) begin
			base = (red >= 18'(base)) ? 9'h000 : base - red[8:0];
		end
		return base[7:0];
	endfunction

	function automatic logic [7:0] lfc_warn_cap(input logic [1:0] sel);
		logic [7:0] c;
		unique case (sel)
			2'h0: c = WARN_CAP0;
			2'h1: c = WARN_CAP1;
			2'h2: c = WARN_CAP2;
			2'h3: c = WARN_CAP3;
		endcase
		return c;
	endfunction

	localparam lfc_state_s RST_STATE = '{
		st: ST_RUN,
		lim_ctrl: LIM_CTRL_RST,
		thr: THR_SLOPE_RST,
		infl: BAT_INFL_RST,
		rec: REC_CTRL_RST,
		vbat: 8'h00,
		status: 8'h00,
		rdata: 8'h00,
		gain: UNITY_GAIN,
		out_gain: 8'h00,
		flt: 4'h0,
		below: 1'b0,
		amp_en: 1'b0,
		mute: 1'b0,
		tries: 2'h0,
		rate_cnt: 13'h0000,
		wait_cnt: 24'h000000
	};

	lfc_state_s s_reg;
	lfc_state_s s_next;
	logic manual_recovery_trigger;
	logic [3:0] cond;
	logic [1:0] mode;
	logic limiting;
	logic [7:0] thr_eff;
	logic [7:0] lvl;
	logic [7:0] cap;
	logic auto_ok;
	logic [1:0] ar_max;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		manual_recovery_trigger = 1'b0;
		cond = {i_sense.vreg_low, i_sense.supply_low, i_sense.overcurrent,
			i_sense.over_temp};
		mode = s_reg.lim_ctrl[1:LC_MODE_LSB];
		limiting = 1'b0;
		thr_eff = lfc_threshold(s_reg.thr, s_reg.infl, s_reg.vbat,
			s_reg.lim_ctrl[LC_TRACK_BIT], s_reg.below);
		lvl = lfc_scale(i_out_level, s_reg.gain);
		cap = UNITY_GAIN;
		auto_ok = 1'b0;
		ar_max = s_reg.rec[4:RC_AR_LSB];
		if (i_ce) begin
			if (i_adc_valid) begin
				s_next.vbat = i_adc_code;
			end
			if (i_reg_wr) begin
				case (i_reg_addr)
					ADDR_LIM_CTRL: s_next.lim_ctrl = i_reg_wdata;
					ADDR_THR_SLOPE: s_next.thr = i_reg_wdata;
					ADDR_BAT_INFL: s_next.infl = i_reg_wdata;
					ADDR_REC_CTRL: begin
						s_next.rec = i_reg_wdata & 8'hdf;
						manual_recovery_trigger = i_reg_wdata[RC_MANUAL_RECOVERY_TRIGGER_BIT];
					end
					default: ;
				endcase
			end

			// hysteresis keeps the limiter from chattering at the point
			if (s_reg.vbat < s_reg.infl) begin
				s_next.below = 1'b1;
			end else if (9'(s_reg.vbat) > 9'(s_reg.infl) + HYST_CODES) begin
				s_next.below = 1'b0;
			end

			// ------------------------------------------------------------
			// limiter gain ramp
			// ------------------------------------------------------------
			unique case (mode)
				MODE_OFF: limiting = 1'b0;
				MODE_ON: limiting = 1'b1;
				MODE_MUTE: limiting = !s_reg.below;
				MODE_LOW: limiting = s_reg.below;
			endcase
			if (s_reg.rate_cnt != 13'h0000) begin
				s_next.rate_cnt = s_reg.rate_cnt - 13'h0001;
			end else if (limiting && lvl > thr_eff) begin
				s_next.rate_cnt = lfc_period(s_reg.lim_ctrl[5:LC_ATR_LSB]);
				if (s_reg.gain != 8'h00) begin
					s_next.gain = s_reg.gain - 8'h01;
				end
			end else if (!limiting || lvl < thr_eff) begin
				s_next.rate_cnt = lfc_period(s_reg.lim_ctrl[7:LC_RRT_LSB]);
				if (s_reg.gain != UNITY_GAIN) begin
					s_next.gain = s_reg.gain + 8'h01;
				end
			end
			s_next.mute = mode == MODE_MUTE && s_reg.below;
			if (i_sense.temp_warn) begin
				cap = lfc_warn_cap(s_reg.rec[7:RC_GAIN_LSB]);
			end
			if (!s_reg.amp_en || s_reg.mute) begin
				s_next.out_gain = 8'h00;
			end else begin
				s_next.out_gain = (s_reg.gain < cap) ? s_reg.gain : cap;
			end

			// ------------------------------------------------------------
			// fault flags and recovery
			// ------------------------------------------------------------
			s_next.flt = s_reg.flt | cond;
			auto_ok = !((s_reg.flt[3] | s_reg.flt[2] | cond[3] | cond[2])
				& !s_reg.rec[RC_UV_BIT])
				&& !((s_reg.flt[0] | cond[0]) & !s_reg.rec[RC_OT_BIT])
				&& !((s_reg.flt[1] | cond[1]) & !s_reg.rec[RC_OC_BIT]);
			unique case (s_reg.st)
				ST_RUN: begin
					if (|cond) begin
						s_next.amp_en = 1'b0;
						// 00 retries without limit, else stop after that many
						if (auto_ok && (ar_max == 2'h0
								|| s_reg.tries < ar_max)) begin
							s_next.st = ST_WAIT;
							s_next.wait_cnt = 24'(RETRY_CYCLES - 1);
						end else begin
							s_next.st = ST_HALT;
						end
					end else if (manual_recovery_trigger) begin
						// power-up leaves the amplifier off until this write
						s_next.amp_en = 1'b1;
						s_next.flt = cond;
						s_next.tries = 2'h0;
					end
				end
				ST_WAIT: begin
					if (manual_recovery_trigger || s_reg.wait_cnt == 24'h000000) begin
						s_next.st = ST_RUN;
						s_next.amp_en = 1'b1;
						s_next.flt = cond;
						if (manual_recovery_trigger) begin
							s_next.tries = 2'h0;
						end else if (s_reg.tries != 2'h3) begin
							s_next.tries = s_reg.tries + 2'h1;
						end
					end else begin
						s_next.wait_cnt = s_reg.wait_cnt - 24'h000001;
					end
				end
				ST_HALT: begin
					if (manual_recovery_trigger) begin
						s_next.st = ST_RUN;
						s_next.amp_en = 1'b1;
						s_next.flt = cond;
						s_next.tries = 2'h0;
					end
				end
			endcase

			s_next.status = {
				s_next.flt[3],
				s_next.flt[2],
				s_reg.gain != UNITY_GAIN || s_reg.mute,
				i_sense.clip,
				s_next.flt[1],
				s_next.flt[0],
				i_sense.temp_warn,
				!s_reg.below
			};

			if (i_reg_rd) begin
				case (i_reg_addr)
					ADDR_LIM_CTRL: s_next.rdata = s_reg.lim_ctrl;
					ADDR_THR_SLOPE: s_next.rdata = s_reg.thr;
					ADDR_BAT_INFL: s_next.rdata = s_reg.infl;
					ADDR_REC_CTRL: s_next.rdata = s_reg.rec;
					ADDR_STATUS: s_next.rdata = s_reg.status;
					ADDR_BAT_VOLT: s_next.rdata = s_reg.vbat;
					default: s_next.rdata = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_reg <= RST_STATE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_reg_rdata = s_reg.rdata;
	assign o_amp_enable = s_reg.amp_en;
	assign o_gain = s_reg.out_gain;
	assign o_mute = s_reg.mute;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	vbat_capture_a: assert property (i_ce && i_adc_valid |=>
		s_reg.vbat == $past(i_adc_code))
		else $error("battery byte not captured");
	vreg_flag_a: assert property (i_ce && i_sense.vreg_low |=>
		s_reg.status[ST_VREG_BIT])
		else $error("regulator undervoltage flag missing");
	supply_flag_a: assert property (i_ce && i_sense.supply_low |=>
		s_reg.status[ST_SUPPLY_BIT])
		else $error("supply undervoltage flag missing");
	oc_flag_a: assert property (i_ce && i_sense.overcurrent |=>
		s_reg.status[ST_OC_BIT] ##1 1)
		else $error("overcurrent flag missing");
	fault_shutdown_a: assert property (i_ce && s_reg.st == ST_RUN
		&& (|cond) |=> !o_amp_enable && s_reg.st != ST_RUN)
		else $error("fault did not shut the amplifier down");
	halt_hold_a: assert property (i_ce && s_reg.st == ST_HALT
		&& !manual_recovery_trigger |=> s_reg.st == ST_HALT && !o_amp_enable)
		else $error("manual halt left without recovery write");
	retry_fire_a: assert property (i_ce && s_reg.st == ST_WAIT
		&& s_reg.wait_cnt == 24'h000000 |=> s_reg.st == ST_RUN
		&& o_amp_enable)
		else $error("automatic retry not attempted");
	hyst_hold_a: assert property (i_ce && s_reg.below
		&& 9'(s_reg.vbat) <= 9'(s_reg.infl) + HYST_CODES |=> s_reg.below)
		else $error("limiter released inside hysteresis band");
	mute_mode_a: assert property (i_ce && mode == MODE_MUTE
		&& s_reg.below |=> o_mute ##1 (o_gain == 8'h00 || !$past(i_ce)))
		else $error("mute mode did not silence output");
	gain_step_a: assert property (##1 9'(s_reg.gain) <=
		9'($past(s_reg.gain)) + 9'h001
		&& 9'(s_reg.gain) + 9'h001 >= 9'($past(s_reg.gain)))
		else $error("gain moved by more than one step");
	ot_flag_a: assert property (i_ce && i_sense.over_temp |=>
		s_reg.status[ST_OT_BIT])
		else $error("overtemperature flag missing");
	warn_flag_a: assert property (i_ce && i_sense.temp_warn |=>
		s_reg.status[ST_WARN_BIT])
		else $error("thermal warning flag missing");
	warn_cap_a: assert property (i_ce && i_sense.temp_warn
		&& s_reg.rec[7:RC_GAIN_LSB] == 2'h2 |=> o_gain <= WARN_CAP2)
		else $error("thermal warning gain cut not applied");
	manual_start_a: assert property (i_ce && manual_recovery_trigger && !(|cond)
		|=> o_amp_enable)
		else $error("recovery write did not start the amplifier");
	retry_limit_a: assert property (i_ce && s_reg.st == ST_RUN
		&& (|cond) && ar_max != 2'h0 && s_reg.tries >= ar_max
		|=> s_reg.st == ST_HALT)
		else $error("automatic attempts exceeded their count");
	manual_select_a: assert property (i_ce && s_reg.st == ST_RUN
		&& i_sense.overcurrent && !s_reg.rec[RC_OC_BIT]
		|=> s_reg.st == ST_HALT)
		else $error("manual overcurrent fault not halted");
	shut_silent_a: assert property (i_ce && !s_reg.amp_en |=>
		o_gain == 8'h00)
		else $error("gain not zero while shut down");
	attack_step_a: assert property (i_ce && limiting
		&& lvl > thr_eff && s_reg.rate_cnt == 13'h0000 && s_reg.gain != 8'h00
		|=> s_reg.gain == $past(s_reg.gain) - 8'h01)
		else $error("attack step missing");
	release_step_a: assert property (i_ce && !limiting
		&& s_reg.rate_cnt == 13'h0000 && s_reg.gain != UNITY_GAIN
		|=> s_reg.gain == $past(s_reg.gain) + 8'h01)
		else $error("release step missing");

	// ----------------------------------------------------------------
	// coverage of the main scenarios
	// ----------------------------------------------------------------
	retry_seen_c: cover property (s_reg.st == ST_RUN ##1 s_reg.st == ST_WAIT
		##[1:1000] s_reg.st == ST_RUN);
	halt_seen_c: cover property (s_reg.st == ST_HALT ##[1:20] manual_recovery_trigger);
	mute_seen_c: cover property (o_mute);
	attack_seen_c: cover property (s_reg.gain == UNITY_GAIN
		##1 s_reg.gain != UNITY_GAIN);
	track_seen_c: cover property (s_reg.lim_ctrl[LC_TRACK_BIT]
		&& s_reg.below && limiting);

endmodule

/* tb/tb.sv */
// self-checking bench for the limiter and fault control block
`timescale 1ns/1ps
module tb
	import lfc_pkg::*;
;
	localparam int RETRY = 8;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_ce = 1'b1;
	logic [7:0] i_reg_addr = 8'h00;
	logic i_reg_wr = 1'b0;
	logic [7:0] i_reg_wdata = 8'h00;
	logic i_reg_rd = 1'b0;
	logic i_adc_valid = 1'b0;
	logic [7:0] i_adc_code = 8'h00;
	lfc_sense_s i_sense = '0;
	logic [7:0] i_out_level = 8'h00;
	logic [7:0] o_reg_rdata;
	logic o_amp_enable;
	logic [7:0] o_gain;
	logic o_mute;
	int error_cnt = 0;
	int check_count = 0;

	lfc_core #(.RETRY_CYCLES(RETRY)) uut (.i_clk(i_clk), .i_rst(i_rst),
		.i_ce(i_ce), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
		.i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
		.i_adc_valid(i_adc_valid), .i_adc_code(i_adc_code),
		.i_sense(i_sense), .i_out_level(i_out_level),
		.o_reg_rdata(o_reg_rdata), .o_amp_enable(o_amp_enable),
		.o_gain(o_gain), .o_mute(o_mute));

	always #2.5 i_clk = ~i_clk;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string m);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		#1;
		d = o_reg_rdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e,
		input string m);
		logic [7:0] d;
		rd(a, d);
		chk(d, e, m);
	endtask

	task automatic rbit(input int b, input logic e, input string m);
		logic [7:0] d;
		rd(ADDR_STATUS, d);
		chk({7'h00, d[b]}, {7'h00, e}, m);
	endtask

	task automatic adc(input logic [7:0] c);
		@(posedge i_clk);
		i_adc_code <= c;
		i_adc_valid <= 1'b1;
		@(posedge i_clk);
		i_adc_valid <= 1'b0;
	endtask

	task automatic sense(input logic [5:0] v);
		@(posedge i_clk);
		i_sense <= lfc_sense_s'(v);
	endtask

	// kinds: 0 amp enable, 1 mute, 2 gain at most e, 3 gain equal e
	task automatic wait_cond(input int w, input logic [7:0] e,
		input int max, input string m);
		logic ok;
		ok = 1'b0;
		for (int i = 0; i < max && !ok; i++) begin
			@(posedge i_clk);
			#1;
			case (w)
				0: ok = (o_amp_enable === e[0]);
				1: ok = (o_mute === e[0]);
				2: ok = ((o_gain <= e) === 1'b1);
				default: ok = (o_gain === e);
			endcase
		end
		check_count++;
		if (!ok) begin
			error_cnt++;
			$display("MISMATCH t=%0t timeout %s", $time, m);
			finish_test();
		end
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		chk({6'h00, o_amp_enable, o_mute}, 8'h00, "amp after reset");
		rchk(8'h08, 8'h00, "ctrl rst");
		rchk(8'h09, 8'hf8, "thr rst");
		rchk(8'h0a, 8'h00, "infl rst");
		rchk(8'h10, 8'h07, "rec rst");
		rchk(8'h11, 8'h01, "status rst");
		rchk(8'h13, 8'h00, "vbat rst");
		wr(8'h09, 8'h5b);
		wr(8'h0a, 8'h3c);
		wr(8'h13, 8'h55);
		wr(8'h11, 8'hff);
		wr(8'h20, 8'hff);
		rchk(8'h09, 8'h5b, "thr rw");
		rchk(8'h0a, 8'h3c, "infl rw");
		rchk(8'h13, 8'h00, "vbat ro");
		rchk(8'h20, 8'h00, "unmapped");
		wr(8'h10, 8'hdf);
		rchk(8'h10, 8'hdf, "rec rw");
		wr(8'h10, 8'h3f);
		rchk(8'h10, 8'h1f, "trigger reads 0");
		wr(8'h08, 8'hf4);
		rchk(8'h08, 8'hf4, "ctrl rw");
		wr(8'h08, 8'h00);
		foreach (i_adc_code[k]) begin
			adc(8'h01 << k);
			rchk(8'h13, 8'h01 << k, "vbat code");
		end
		adc(8'ha9);
		rchk(8'h13, 8'ha9, "vbat a9");
		$display("test registers done");
	endtask

	task automatic t_faults();
		int sb[4] = '{5, 4, 3, 2};
		int st[4] = '{7, 6, 3, 2};
		for (int i = 0; i < 4; i++) begin
			wr(8'h10, 8'h20);
			wait_cond(0, 8'h01, 4, "manual start");
			sense(6'h01 << sb[i]);
			wait_cond(0, 8'h00, 4, "shut on fault");
			rbit(st[i], 1'b1, "flag");
			sense(6'h00);
			repeat (4 * RETRY) @(posedge i_clk);
			#1;
			chk({7'h00, o_amp_enable}, 8'h00, "stays halted");
			rbit(st[i], 1'b1, "flag sticky");
			wr(8'h10, 8'h20);
			wait_cond(0, 8'h01, 4, "manual retry");
			rbit(st[i], 1'b0, "flag reload");
		end
		sense(6'h02);
		rbit(1, 1'b1, "warn flag");
		sense(6'h00);
		$display("test faults done");
	endtask

	task automatic t_recovery();
		logic [5:0] sv[3] = '{6'h08, 6'h04, 6'h10};
		logic [7:0] sel;
		for (int k = 0; k < 3; k++) begin
			for (int a = 0; a < 2; a++) begin
				sel = (a == 1) ? 8'h07 : (8'h07 & ~(8'h01 << k));
				wr(8'h10, 8'h20 | sel);
				wait_cond(0, 8'h01, 4, "start");
				sense(sv[k]);
				wait_cond(0, 8'h00, 4, "shut");
				if (a == 1) begin
					wait_cond(0, 8'h01, 2 * RETRY + 4, "retry");
					wait_cond(0, 8'h00, 4, "refault");
				end
				sense(6'h00);
				repeat (4 * RETRY) @(posedge i_clk);
				#1;
				chk({7'h00, o_amp_enable}, {7'h00, a[0]}, "select");
			end
		end
		wr(8'h10, 8'h2f);
		sense(6'h08);
		repeat (10 * RETRY) @(posedge i_clk);
		sense(6'h00);
		repeat (4 * RETRY) @(posedge i_clk);
		#1;
		chk({7'h00, o_amp_enable}, 8'h00, "retry limit");
		$display("test recovery done");
	endtask

	task automatic setup(input logic [7:0] c, input logic [7:0] t,
		input logic [7:0] vb, input logic [7:0] lv);
		wr(8'h08, c);
		wr(8'h09, t);
		wr(8'h0a, 8'h80);
		adc(vb);
		@(posedge i_clk);
		i_out_level <= lv;
		repeat (300) @(posedge i_clk);
		#1;
	endtask

	task automatic t_limiter();
		wr(8'h10, 8'h27);
		wait_cond(0, 8'h01, 4, "start");
		setup(8'h00, 8'h00, 8'hc0, 8'h40);
		chk(o_gain, 8'hff, "mode off");
		setup(8'h01, 8'h00, 8'hc0, 8'h10);
		chk(o_gain, 8'hff, "at threshold");
		setup(8'h01, 8'h00, 8'hc0, 8'h12);
		wait_cond(2, 8'hfe, 200, "attack");
		rbit(5, 1'b1, "engaged");
		setup(8'h01, 8'hf8, 8'hc0, 8'h80);
		wait_cond(3, 8'hff, 3000, "release");
		setup(8'h03, 8'h00, 8'hc0, 8'h40);
		chk(o_gain, 8'hff, "above point");
		setup(8'h03, 8'h00, 8'h40, 8'h40);
		wait_cond(2, 8'hfe, 200, "below point");
		setup(8'h01, 8'h20, 8'h60, 8'h1f);
		wait_cond(3, 8'hff, 3000, "fixed thr");
		setup(8'h05, 8'h20, 8'h60, 8'h1f);
		wait_cond(2, 8'hfe, 200, "tracking");
		setup(8'h02, 8'h00, 8'h40, 8'h00);
		wait_cond(1, 8'h01, 8, "mute");
		wait_cond(3, 8'h00, 8, "mute gain");
		adc(8'h82);
		repeat (20) @(posedge i_clk);
		#1;
		chk({7'h00, o_mute}, 8'h01, "hysteresis");
		adc(8'h85);
		wait_cond(1, 8'h00, 8, "unmute");
		$display("test limiter done");
	endtask

	task automatic t_thermal();
		setup(8'h00, 8'hf8, 8'hc0, 8'h00);
		wr(8'h10, 8'ha7);
		sense(6'h02);
		wait_cond(2, 8'h80, 9000, "warn cut");
		sense(6'h00);
		$display("test thermal done");
	endtask

	task automatic t_hold();
		@(posedge i_clk);
		i_ce <= 1'b0;
		wr(8'h0a, 8'h11);
		adc(8'h33);
		@(posedge i_clk);
		i_ce <= 1'b1;
		rchk(8'h0a, 8'h80, "frozen write");
		rchk(8'h13, 8'hc0, "frozen adc");
		$display("test clock enable done");
	endtask

	initial begin
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		t_regs();
		t_faults();
		t_recovery();
		t_limiter();
		t_thermal();
		t_hold();
		finish_test();
	end
endmodule
